// ---- core/bmx_defines.svh ----
/*
  constants of the four-by-five bus matrix: port indices, address map,
  connectivity table and transfer occupancy counts.
  assumes inclusion by the package and the matrix files only.
*/
`ifndef BMX_DEFINES_SVH
`define BMX_DEFINES_SVH

// --------------------------------------------------------------
// port counts and master indices
// --------------------------------------------------------------
`define BMX_NUM_MST      4
`define BMX_NUM_SLV      5
`define BMX_MST_CPU_ID   2'h0
`define BMX_MST_CPU_SYS  2'h1
`define BMX_MST_DMA      2'h2
`define BMX_MST_CRC      2'h3

// --------------------------------------------------------------
// slave indices
// --------------------------------------------------------------
`define BMX_SLV_SRAM     3'h0
`define BMX_SLV_ROM      3'h1
`define BMX_SLV_FLASH    3'h2
`define BMX_SLV_EXTBUS   3'h3
`define BMX_SLV_BRIDGE   3'h4

// --------------------------------------------------------------
// address map, shared by every decoder
// --------------------------------------------------------------
`define BMX_SRAM_BASE    32'h2000_0000
`define BMX_SRAM_MASK    32'hf000_0000
`define BMX_ROM_BASE     32'h0080_0000
`define BMX_ROM_MASK     32'hffc0_0000
`define BMX_FLASH_BASE   32'h0040_0000
`define BMX_FLASH_MASK   32'hffc0_0000
`define BMX_EXTBUS_BASE  32'h6000_0000
`define BMX_EXTBUS_MASK  32'hf000_0000
`define BMX_BRIDGE_BASE  32'h4000_0000
`define BMX_BRIDGE_MASK  32'hf000_0000

// --------------------------------------------------------------
// wired paths, bit (slave*4 + master)
// --------------------------------------------------------------
`define BMX_CONN         32'h0006_e9de

// --------------------------------------------------------------
// dma bus occupancy in master clock cycles
// --------------------------------------------------------------
`define BMX_DMA_M2P_CYC  1
`define BMX_DMA_P2M_CYC  2

`endif

// ---- core/bmx_pkg.sv ----
/*
  types and shared decoding of the bus matrix.
  assumes bmx_defines.svh on the include path.
*/
`include "bmx_defines.svh"

package bmx_pkg;

  typedef logic [31:0]       bmx_addr_t;
  typedef logic [31:0]       bmx_data_t;
  typedef logic [1:0]        bmx_midx_t;
  typedef logic [2:0]        bmx_sidx_t;
  typedef logic [3:0]        bmx_mvec_t;
  typedef logic [4:0]        bmx_svec_t;
  typedef logic [3:0][31:0]  bmx_mbus_t;
  typedef logic [4:0][31:0]  bmx_sbus_t;

  typedef struct packed {
    logic      hit;
    bmx_sidx_t idx;
  } bmx_dec_t;

  // --------------------------------------------------------------
  // address decode, one map for all masters
  // --------------------------------------------------------------
  function automatic bmx_dec_t bmx_decode(bmx_addr_t a);
    bmx_dec_t d;
    d = '{hit: 1'b1, idx: `BMX_SLV_SRAM};
    if ((a & `BMX_SRAM_MASK) == `BMX_SRAM_BASE) d.idx = `BMX_SLV_SRAM;
    else if ((a & `BMX_ROM_MASK) == `BMX_ROM_BASE) d.idx = `BMX_SLV_ROM;
    else if ((a & `BMX_FLASH_MASK) == `BMX_FLASH_BASE) d.idx = `BMX_SLV_FLASH;
    else if ((a & `BMX_EXTBUS_MASK) == `BMX_EXTBUS_BASE) d.idx = `BMX_SLV_EXTBUS;
    else if ((a & `BMX_BRIDGE_MASK) == `BMX_BRIDGE_BASE) d.idx = `BMX_SLV_BRIDGE;
    else d.hit = 1'b0;
    return d;
  endfunction : bmx_decode

  // --------------------------------------------------------------
  // path table lookup
  // --------------------------------------------------------------
  function automatic logic bmx_wired(bmx_midx_t m, bmx_sidx_t s);
    logic [31:0] c;
    c = `BMX_CONN;
    return c[{s, m}];
  endfunction : bmx_wired

endpackage : bmx_pkg

// ---- core/bmx_arb_if.sv ----
/*
  link between the matrix core and one slave arbiter.
  assumes one instance per slave, all on the master clock.
*/
`timescale 1ns/1ns

interface bmx_arb_if;
  logic [3:0] req;
  logic       rr;
  logic       p2m;
  logic       done;
  logic       start;
  logic [1:0] pick;
  logic       busy;
  logic       hold;
  logic [1:0] owner;

  modport arb (input req, rr, p2m, done, output start, pick, busy, hold, owner);
  modport mtx (output req, rr, p2m, done, input start, pick, busy, hold, owner);
endinterface : bmx_arb_if

// ---- core/bmx_arbiter.sv ----
/*
  per-slave arbiter: fixed or round-robin choice among four masters,
  holds the slave until its answer, adds dma occupancy after writes to memory.
  assumes requests stay up until done and come from the master clock domain.
*/
`timescale 1ns/1ns
`include "bmx_defines.svh"

module bmx_arbiter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // matrix side
  bmx_arb_if.arb   ai
);
  import bmx_pkg::*;

  typedef struct packed {
    logic      busy;
    logic      hold;
    logic      p2m;
    bmx_midx_t owner;
    bmx_midx_t last;
  } bmx_arb_st_t;

  bmx_arb_st_t st_q;
  bmx_arb_st_t st_d;
  bmx_midx_t   pick;
  logic        start;

  // --------------------------------------------------------------
  // choice and occupancy
  // --------------------------------------------------------------
  always_comb begin
    logic      found;
    bmx_midx_t idx;
    found = 1'b0;
    idx   = 2'h0;
    pick  = 2'h0;
    for (int i = 0; i < `BMX_NUM_MST; i++) begin
      idx = ai.rr ? bmx_midx_t'(st_q.last + 2'(i) + 2'h1) : 2'(i);
      if (ai.req[idx] && !found) begin
        found = 1'b1;
        pick  = idx;
      end
    end
    start = !st_q.busy && !st_q.hold && (|ai.req);
    st_d  = st_q;
    if (st_q.busy && ai.done) begin
      st_d.busy = 1'b0;
      st_d.hold = st_q.p2m && (`BMX_DMA_P2M_CYC > `BMX_DMA_M2P_CYC);
    end else if (st_q.hold) begin
      st_d.hold = 1'b0;
    end else if (start) begin
      st_d.busy  = 1'b1;
      st_d.owner = pick;
      st_d.last  = pick;
      st_d.p2m   = ai.p2m && (pick == `BMX_MST_DMA);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ai.start = start;
  assign ai.pick  = pick;
  assign ai.busy  = st_q.busy;
  assign ai.hold  = st_q.hold;
  assign ai.owner = st_q.owner;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  dma_extra_cycle_a : assert property (@(posedge clk) disable iff (!rst_n)
    st_q.busy && ai.done && st_q.p2m |=> st_q.hold && !st_q.busy ##1 !st_q.hold && !st_q.busy)
    else $error("dma write to memory did not occupy the slave one extra cycle");

  rr_next_master_a : assert property (@(posedge clk) disable iff (!rst_n)
    start && ai.rr && ai.req[2'(st_q.last + 2'h1)] |=> st_q.owner == $past(2'(st_q.last + 2'h1)))
    else $error("round robin skipped the next requesting master");

  grant_held_a : assert property (@(posedge clk) disable iff (!rst_n)
    st_q.busy && !ai.done |=> st_q.busy && st_q.owner == $past(st_q.owner))
    else $error("slave ownership changed before the answer");

endmodule : bmx_arbiter

// ---- core/bmx_matrix.sv ----
/*
  four-master, five-slave bus matrix with one decoder per master and one
  arbiter per slave; unwired paths and unmapped addresses answer with an error.
  assumes masters and slaves run on MCLK and masters hold a request until M_READY.
*/
`timescale 1ns/1ns
`include "bmx_defines.svh"

// Function
// - four masters run accesses at the same time whenever they target different free slaves.
// - each master has its own address decoder and all decoders use the same map.
// - each of the five slaves has its own arbiter whose policy is chosen per slave.
// - master 0 is the cpu instruction bus, 1 the cpu system bus, 2 the peripheral_dma_engine, 3 the crc_calc_unit.
// - slave 0 is sram, 1 rom, 2 flash, 3 the external bus interface and 4 the peripheral bridge.
// - the cpu instruction bus reaches only rom and flash.
// - the cpu system bus reaches sram, the external bus and the bridge, never rom or flash.
// - the peripheral_dma_engine reaches sram, rom, the external bus and the bridge, never flash.
// - the crc_calc_unit reaches sram, rom, flash and the external bus, never the bridge.
// - the peripherals behind the bridge run on master_clock, the clock of the matrix.
// - the peripheral_dma_engine holds a slave one cycle per memory-to-peripheral and two per peripheral-to-memory transfer.
module bmx_matrix (
  // master_clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  // arbitration policy, one bit per slave: 1 round robin, 0 fixed
  input  wire bmx_pkg::bmx_svec_t ARB_RR,
  // master request ports
  input  wire bmx_pkg::bmx_mvec_t M_VALID,
  input  wire bmx_pkg::bmx_mbus_t M_ADDR,
  input  wire bmx_pkg::bmx_mvec_t M_WRITE,
  input  wire bmx_pkg::bmx_mbus_t M_WDATA,
  input  wire logic              DMA_P2M,
  // master answer ports
  output wire bmx_pkg::bmx_mvec_t M_READY,
  output wire bmx_pkg::bmx_mvec_t M_ERR,
  output wire bmx_pkg::bmx_mbus_t M_RDATA,
  // slave ports
  output wire bmx_pkg::bmx_svec_t S_SEL,
  output wire bmx_pkg::bmx_sbus_t S_ADDR,
  output wire bmx_pkg::bmx_svec_t S_WRITE,
  output wire bmx_pkg::bmx_sbus_t S_WDATA,
  input  wire bmx_pkg::bmx_svec_t S_READY,
  input  wire bmx_pkg::bmx_sbus_t S_RDATA
);
  import bmx_pkg::*;

  typedef struct packed {
    bmx_sbus_t s_addr;
    bmx_sbus_t s_wdata;
    bmx_svec_t s_write;
    bmx_mbus_t m_rdata;
    bmx_mvec_t m_ready;
    bmx_mvec_t m_err;
    bmx_mvec_t pend;
  } bmx_mtx_st_t;

  bmx_mtx_st_t       st_q;
  bmx_mtx_st_t       st_d;
  bmx_dec_t          dec   [`BMX_NUM_MST];
  bmx_mvec_t         m_free;
  bmx_mvec_t         m_bad;
  logic [4:0][3:0]   req_w;
  bmx_svec_t         s_start;
  bmx_svec_t         s_busy;
  bmx_svec_t         s_hold;
  logic [4:0][1:0]   s_pick;
  logic [4:0][1:0]   s_owner;
  logic [3:0][4:0]   grant_m;

  // --------------------------------------------------------------
  // per-master decoders
  // --------------------------------------------------------------
  for (genvar m = 0; m < `BMX_NUM_MST; m++) begin : g_mst
    assign dec[m]    = bmx_decode(M_ADDR[m]);
    assign m_free[m] = M_VALID[m] && !st_q.pend[m] && !st_q.m_ready[m];
    assign m_bad[m]  = m_free[m] && !(dec[m].hit && bmx_wired(2'(m), dec[m].idx));
  end

  // --------------------------------------------------------------
  // per-slave arbiters
  // --------------------------------------------------------------
  bmx_arb_if ai [`BMX_NUM_SLV] ();

  for (genvar s = 0; s < `BMX_NUM_SLV; s++) begin : g_slv
    for (genvar m = 0; m < `BMX_NUM_MST; m++) begin : g_req
      // only wired paths ever raise a request
      assign req_w[s][m] = m_free[m] && dec[m].hit && dec[m].idx == 3'(s) &&
                           bmx_wired(2'(m), 3'(s));
    end
    assign ai[s].req  = req_w[s];
    assign ai[s].rr   = ARB_RR[s];
    assign ai[s].p2m  = DMA_P2M;
    assign ai[s].done = S_READY[s];
    assign s_start[s] = ai[s].start;
    assign s_pick[s]  = ai[s].pick;
    assign s_busy[s]  = ai[s].busy;
    assign s_hold[s]  = ai[s].hold;
    assign s_owner[s] = ai[s].owner;

    bmx_arbiter u_arb (
      .clk   (MCLK),
      .rst_n (RST_N),
      .ai    (ai[s])
    );
  end

  // --------------------------------------------------------------
  // routing and answers
  // --------------------------------------------------------------
  always_comb begin
    st_d         = st_q;
    st_d.m_ready = '0;
    st_d.m_err   = '0;
    for (int s = 0; s < `BMX_NUM_SLV; s++) begin
      if (s_start[s]) begin
        st_d.s_addr[s]          = M_ADDR[s_pick[s]];
        st_d.s_wdata[s]         = M_WDATA[s_pick[s]];
        st_d.s_write[s]         = M_WRITE[s_pick[s]];
        st_d.pend[s_pick[s]]    = 1'b1;
      end
      if (s_busy[s] && S_READY[s]) begin
        st_d.m_ready[s_owner[s]] = 1'b1;
        st_d.m_rdata[s_owner[s]] = S_RDATA[s];
        st_d.pend[s_owner[s]]    = 1'b0;
      end
    end
    for (int m = 0; m < `BMX_NUM_MST; m++) begin
      if (m_bad[m]) begin
        st_d.m_ready[m] = 1'b1;
        st_d.m_err[m]   = 1'b1;
        st_d.m_rdata[m] = 32'h0000_0000;
      end
    end
  end

  // bridge peripherals share this clock, no crossing on slave 4
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign S_SEL   = s_busy;
  assign S_ADDR  = st_q.s_addr;
  assign S_WDATA = st_q.s_wdata;
  assign S_WRITE = st_q.s_write;
  assign M_READY = st_q.m_ready;
  assign M_ERR   = st_q.m_err;
  assign M_RDATA = st_q.m_rdata;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  for (genvar s = 0; s < `BMX_NUM_SLV; s++) begin : g_chk
    start_selects_a : assert property (@(posedge MCLK) disable iff (!RST_N)
      s_start[s] |=> S_SEL[s] && S_ADDR[s] == $past(M_ADDR[s_pick[s]]))
      else $error("granted request did not reach its slave next cycle");

    answer_routed_a : assert property (@(posedge MCLK) disable iff (!RST_N)
      S_SEL[s] && S_READY[s] |=> M_READY[$past(s_owner[s])] && !M_ERR[$past(s_owner[s])] &&
      M_RDATA[$past(s_owner[s])] == $past(S_RDATA[s]))
      else $error("slave answer not returned to its owner");

    path_wired_a : assert property (@(posedge MCLK) disable iff (!RST_N)
      S_SEL[s] |-> bmx_wired(s_owner[s], 3'(s)))
      else $error("slave selected over an unwired path");

    hold_blocks_a : assert property (@(posedge MCLK) disable iff (!RST_N)
      s_hold[s] |=> !S_SEL[s])
      else $error("slave granted during the dma extra cycle");

    request_stands_a : assert property (@(posedge MCLK) disable iff (!RST_N)
      S_SEL[s] && !S_READY[s] |=> S_SEL[s] && $stable(S_ADDR[s]) && $stable(S_WDATA[s]))
      else $error("slave request changed before its answer");
  end

  // --------------------------------------------------------------
  // per-master answer and grant checks
  // --------------------------------------------------------------
  for (genvar m = 0; m < `BMX_NUM_MST; m++) begin : g_mchk
    for (genvar s = 0; s < `BMX_NUM_SLV; s++) begin : g_gnt
      assign grant_m[m][s] = s_start[s] && s_pick[s] == 2'(m);
    end

    error_answer_a : assert property (@(posedge MCLK) disable iff (!RST_N)
      m_bad[m] |=> M_READY[m] && M_ERR[m] && M_RDATA[m] == 32'h0000_0000)
      else $error("unwired or unmapped access did not answer with an error");

    ready_pulse_a : assert property (@(posedge MCLK) disable iff (!RST_N)
      M_READY[m] |=> !M_READY[m])
      else $error("master answer stood longer than one cycle");

    single_grant_a : assert property (@(posedge MCLK) disable iff (!RST_N)
      $onehot0(grant_m[m]))
      else $error("one master granted by two slaves at once");
  end

  id_bus_paths_a : assert property (@(posedge MCLK) disable iff (!RST_N)
    !((S_SEL[0] || S_SEL[3] || S_SEL[4]) &&
      (s_owner[0] == 2'h0 && S_SEL[0] || s_owner[3] == 2'h0 && S_SEL[3] || s_owner[4] == 2'h0 && S_SEL[4])))
    else $error("instruction bus reached a forbidden slave");

  sys_bus_paths_a : assert property (@(posedge MCLK) disable iff (!RST_N)
    !(S_SEL[1] && s_owner[1] == 2'h1) && !(S_SEL[2] && s_owner[2] == 2'h1))
    else $error("system bus reached rom or flash");

  dma_no_flash_a : assert property (@(posedge MCLK) disable iff (!RST_N)
    !(S_SEL[2] && s_owner[2] == 2'h2))
    else $error("dma engine reached flash");

  crc_no_bridge_a : assert property (@(posedge MCLK) disable iff (!RST_N)
    !(S_SEL[4] && s_owner[4] == 2'h3))
    else $error("crc unit reached the bridge");

  same_decode_a : assert property (@(posedge MCLK) disable iff (!RST_N)
    M_ADDR[0] == M_ADDR[3] |-> dec[0] == dec[3])
    else $error("decoders disagree on one address");

  bad_errors_a : assert property (@(posedge MCLK) disable iff (!RST_N)
    m_bad[0] |=> M_READY[0] && M_ERR[0] ##1 !M_READY[0])
    else $error("bad access did not end with a one-cycle error");

endmodule : bmx_matrix

// ---- bench/bmx_slave_model.sv ----
/*
  five slave models behind the bus matrix: one word of storage each,
  answer after a set number of wait cycles, read data = stored ^ address.
  assumes the matrix slave ports and the master clock.
*/
`timescale 1ns/1ns

module bmx_slave_model (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // slave requests
  input  wire bmx_pkg::bmx_svec_t sel,
  input  wire bmx_pkg::bmx_sbus_t addr,
  input  wire bmx_pkg::bmx_svec_t write,
  input  wire bmx_pkg::bmx_sbus_t wdata,
  input  wire logic [1:0]         wait_cyc,
  // slave answers
  output bmx_pkg::bmx_svec_t      ready,
  output bmx_pkg::bmx_sbus_t      rdata
);
  import bmx_pkg::*;
  logic [4:0][1:0]  cnt_q;
  logic [4:0][31:0] mem_q;

  // --------------------------------------------------------------
  // answer logic; idle read data toggles every cycle
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= '0;
      rdata <= '0;
      cnt_q <= '0;
      mem_q <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        ready[i] <= 1'b0;
        rdata[i] <= ~rdata[i];
        if (sel[i] && !ready[i]) begin
          if (cnt_q[i] == wait_cyc) begin
            ready[i] <= 1'b1;
            rdata[i] <= mem_q[i] ^ addr[i];
            cnt_q[i] <= 2'h0;
            if (write[i]) mem_q[i] <= wdata[i];
          end else begin
            cnt_q[i] <= cnt_q[i] + 2'h1;
          end
        end
      end
    end
  end
endmodule : bmx_slave_model

// ---- bench/bmx_matrix_tb.sv ----
/*
  self-checking bench of the bus matrix: path table loop, concurrency,
  arbitration policy and dma occupancy.
  assumes core files and bmx_slave_model compiled before it.
*/
`timescale 1ns/1ns

module bmx_matrix_tb;
  import bmx_pkg::*;
  logic mclk, rst_n, dma_p2m;
  bmx_svec_t arb_rr, s_sel, s_write, s_ready;
  bmx_mvec_t m_valid, m_write, m_ready, m_err;
  bmx_mbus_t m_addr, m_wdata, m_rdata;
  bmx_sbus_t s_addr, s_wdata, s_rdata;
  logic [1:0] slv_wait;
  int error_cnt, n_tests, cyc;
  time t_done [4];
  localparam logic [31:0] ADDR [6] = '{32'h2000_0010, 32'h0080_0004, 32'h0040_0008,
                                       32'h6000_000c, 32'h4000_0020, 32'h1000_0000};
  localparam logic [5:0] WIRED [4] = '{6'b00_0110, 6'b01_1001, 6'b01_1011, 6'b00_1111};

  bmx_matrix uut (.MCLK(mclk), .RST_N(rst_n), .ARB_RR(arb_rr), .M_VALID(m_valid), .M_ADDR(m_addr),
    .M_WRITE(m_write), .M_WDATA(m_wdata), .DMA_P2M(dma_p2m), .M_READY(m_ready), .M_ERR(m_err),
    .M_RDATA(m_rdata), .S_SEL(s_sel), .S_ADDR(s_addr), .S_WRITE(s_write), .S_WDATA(s_wdata),
    .S_READY(s_ready), .S_RDATA(s_rdata));
  bmx_slave_model slaves (.clk(mclk), .rst_n(rst_n), .sel(s_sel), .addr(s_addr), .write(s_write),
    .wdata(s_wdata), .wait_cyc(slv_wait), .ready(s_ready), .rdata(s_rdata));

  // --------------------------------------------------------------
  // clock, timeout, shared tasks
  // --------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic acc(input int m, input logic [31:0] a, input logic wr, input logic [31:0] wd,
                     output logic e, output logic [31:0] d);
    int k;
    k = 0;
    m_valid[m] <= 1'b1;
    m_addr[m]  <= a;
    m_write[m] <= wr;
    m_wdata[m] <= wd;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (m_ready[m] !== 1'b1 && k < 200);
    e = m_err[m];
    d = m_rdata[m];
    t_done[m] = $time;
    @(posedge mclk);
    m_valid[m] <= 1'b0;
    @(posedge mclk);
  endtask : acc

  task automatic pair(input int ma, input int mb, input logic [31:0] a);
    logic e0, e1;
    logic [31:0] d0, d1;
    fork
      acc(ma, a, 1'b0, 32'h0000_0000, e0, d0);
      acc(mb, a, 1'b0, 32'h0000_0000, e1, d1);
    join
  endtask : pair

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic e;
    logic [31:0] d, wd;
    time lat0, lat1;
    rst_n = 1'b0;
    dma_p2m = 1'b0;
    arb_rr = 5'h00;
    m_valid = '0;
    m_write = '0;
    m_addr = '0;
    m_wdata = '0;
    slv_wait = 2'h0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (16) @(posedge mclk);
    chk({27'h0, s_sel}, 32'h0000_0000);
    chk({28'h0, m_ready}, 32'h0000_0000);
    rst_n <= 1'b1;
    @(posedge mclk);
    // path table: write then read each slave and an unmapped place
    for (int r = 0; r < 24; r++) begin
      slv_wait <= r[1:0];
      wd = ADDR[r % 6] + 32'h1111_0000 + r;
      acc(r / 6, ADDR[r % 6], 1'b1, wd, e, d);
      chk({31'h0, e}, {31'h0, ~WIRED[r / 6][r % 6]});
      acc(r / 6, ADDR[r % 6], 1'b0, 32'h0000_0000, e, d);
      chk({31'h0, e}, {31'h0, ~WIRED[r / 6][r % 6]});
      chk(d, WIRED[r / 6][r % 6] ? (wd ^ ADDR[r % 6]) : 32'h0000_0000);
    end
    // four masters on four slaves finish together
    slv_wait <= 2'h1;
    fork
      acc(0, ADDR[1], 1'b0, 32'h0000_0000, e, d);
      acc(1, ADDR[0], 1'b0, 32'h0000_0000, e, d);
      acc(2, ADDR[4], 1'b0, 32'h0000_0000, e, d);
      acc(3, ADDR[2], 1'b0, 32'h0000_0000, e, d);
    join
    for (int m = 1; m < 4; m++) chk(32'(t_done[m]), 32'(t_done[0]));
    // fixed policy: lowest index first; round robin after last grant
    pair(1, 2, ADDR[0]);
    chk({31'h0, t_done[1] < t_done[2]}, 32'h0000_0001);
    arb_rr <= 5'h01;
    pair(2, 3, ADDR[0]);
    chk({31'h0, t_done[3] < t_done[2]}, 32'h0000_0001);
    arb_rr <= 5'h00;
    pair(2, 3, ADDR[0]);
    chk({31'h0, t_done[2] < t_done[3]}, 32'h0000_0001);
    // dma peripheral-to-memory holds the slave one cycle longer
    pair(2, 3, ADDR[0]);
    lat0 = t_done[3] - t_done[2];
    dma_p2m <= 1'b1;
    pair(2, 3, ADDR[0]);
    lat1 = t_done[3] - t_done[2];
    dma_p2m <= 1'b0;
    chk(32'(lat1 - lat0), 32'h0000_0008);
    // reset in mid access clears the answers, then a clean access after release
    m_valid[1] <= 1'b1;
    m_addr[1] <= ADDR[0];
    repeat (2) @(posedge mclk);
    chk({27'h0, s_sel}, 32'h0000_0001);
    rst_n <= 1'b0;
    m_valid[1] <= 1'b0;
    #1;
    chk({27'h0, s_sel}, 32'h0000_0000);
    chk({28'h0, m_ready}, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    acc(1, ADDR[0], 1'b0, 32'h0000_0000, e, d);
    chk({31'h0, e}, 32'h0000_0000);
    chk(d, ADDR[0]);
    finish_test();
  end
endmodule : bmx_matrix_tb
